// ### taoi_defs.vh
// constants for the transmit all-ones insertion block
`ifndef TAOI_DEFS_VH
`define TAOI_DEFS_VH
// ----------------------------------------
// jitter attenuator mode codes
// ----------------------------------------
`define TAOI_JA_FIFO16 2'h0
`define TAOI_JA_FIFO32 2'h1
`define TAOI_JA_DESYNC 2'h2
`define TAOI_JA_OFF 2'h3
// ----------------------------------------
// loopback codes
// ----------------------------------------
`define TAOI_LB_NONE 2'h0
`define TAOI_LB_ANALOG 2'h1
`define TAOI_LB_REMOTE 2'h2
`define TAOI_LB_DIGITAL 2'h3
// ----------------------------------------
// fifo sizing and de-sync start level
// ----------------------------------------
`define TAOI_FIFO_DEPTH 4
`define TAOI_FIFO_AW 2
`define TAOI_DESYNC_START 2
`endif

// ### taoi_fifo.v
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module taoi_fifo #(
    parameter WIDTH = 2,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign level = count_reg;

    always @*
    begin
        out_data = mem[rd_ptr_reg];
    end

    always @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_ptr_reg + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ### taoi_tx_all_ones.v
// one transmit channel: all-ones insertion, loopback gating, de-sync buffering
`timescale 1ns/1ps
`include "taoi_defs.vh"
module taoi_tx_all_ones (
    input wire clk,
    input wire resetn,
    input wire host_mode,
    input wire all_ones_force,
    input wire all_ones_ctrl_bit,
    input wire [1:0] loopback_mode,
    input wire [1:0] ja_mode,
    input wire ja_in_tx_path,
    input wire transmit_clock_in,
    input wire tx_pos_in,
    input wire tx_neg_in,
    input wire rx_clock_in,
    input wire rx_pos_in,
    input wire rx_neg_in,
    output reg line_out_pos,
    output reg line_out_neg,
    output reg loop_out_pos,
    output reg loop_out_neg,
    output wire all_ones_active,
    output wire desync_overflow
);
    // ----------------------------------------
    // state codes
    // ----------------------------------------
    localparam ST_DATA = 3'b001;
    localparam ST_ONES = 3'b010;
    localparam ST_BLOCK = 3'b100;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // pins cross from outside; clocks are sampled, so their rate must be well under clk/2
    reg [6:0] sync1_reg;
    reg [6:0] sync2_reg;
    reg tclk_prev_reg;
    reg rclk_prev_reg;
    wire force_s = sync2_reg[0];
    wire tclk_s = sync2_reg[1];
    wire tpos_s = sync2_reg[2];
    wire tneg_s = sync2_reg[3];
    wire rclk_s = sync2_reg[4];
    wire rpos_s = sync2_reg[5];
    wire rneg_s = sync2_reg[6];

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
            tclk_prev_reg <= 1'b0;
            rclk_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {rx_neg_in, rx_pos_in, rx_clock_in, tx_neg_in, tx_pos_in,
                transmit_clock_in, all_ones_force};
            sync2_reg <= sync1_reg;
            tclk_prev_reg <= tclk_s;
            rclk_prev_reg <= rclk_s;
        end
    end

    wire tclk_rise = tclk_s && !tclk_prev_reg;
    wire rclk_rise = rclk_s && !rclk_prev_reg;

    // ----------------------------------------
    // mode decoding
    // ----------------------------------------
    function blocks_all_ones;
        input [1:0] lb;
        begin
            blocks_all_ones = (lb == `TAOI_LB_ANALOG) || (lb == `TAOI_LB_REMOTE);
        end
    endfunction

    wire request = host_mode ? all_ones_ctrl_bit : force_s;
    wire remote_lb = (loopback_mode == `TAOI_LB_REMOTE);
    wire desync_on = ja_in_tx_path && (ja_mode == `TAOI_JA_DESYNC) && !remote_lb;
    // remote loopback times the line from the receive clock
    wire tx_tick = remote_lb ? rclk_rise : tclk_rise;

    // ----------------------------------------
    // control state machine
    // ----------------------------------------
    reg [2:0] state_reg;
    reg [2:0] state_next;

    always @*
    begin
        case (state_reg)
            ST_DATA:
            begin
                if (request && blocks_all_ones(loopback_mode))
                    state_next = ST_BLOCK;
                else if (request)
                    state_next = ST_ONES;
                else
                    state_next = ST_DATA;
            end
            ST_ONES:
            begin
                if (!request)
                    state_next = ST_DATA;
                else if (blocks_all_ones(loopback_mode))
                    state_next = ST_BLOCK;
                else
                    state_next = ST_ONES;
            end
            ST_BLOCK:
            begin
                if (!request)
                    state_next = ST_DATA;
                else if (!blocks_all_ones(loopback_mode))
                    state_next = ST_ONES;
                else
                    state_next = ST_BLOCK;
            end
            default:
                state_next = ST_DATA;
        endcase
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= ST_DATA;
        else
            state_reg <= state_next;
    end

    assign all_ones_active = (state_reg == ST_ONES);

    // ----------------------------------------
    // de-sync buffer
    // ----------------------------------------
    // gapped mapper bits land here on their own clock edge and leave on tx_tick, which in de-sync mode is that same gapped edge
    wire [1:0] fifo_out;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`TAOI_FIFO_AW:0] fifo_level;
    reg started_reg;
    wire fifo_write = desync_on && tclk_rise;
    wire fifo_read = started_reg && tx_tick;

    taoi_fifo #(
        .WIDTH(2),
        .DEPTH(`TAOI_FIFO_DEPTH),
        .AW(`TAOI_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_data({tpos_s, tneg_s}),
        .in_valid(fifo_write),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_read),
        .level(fifo_level)
    );

    // the mapper cannot be stalled, so a write into a full buffer is counted as a loss
    assign desync_overflow = fifo_write && !fifo_in_ready;

    // re-arms on a parked buffer too, else bits left from an earlier run would never drain
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            started_reg <= 1'b0;
        else if (!desync_on)
            started_reg <= 1'b0;
        else if (!started_reg || !fifo_out_valid)
            started_reg <= (fifo_level >= `TAOI_DESYNC_START);
    end

    // ----------------------------------------
    // line output
    // ----------------------------------------
    reg mark_phase_reg;
    wire [1:0] rx_pair = {rpos_s, rneg_s};
    wire [1:0] tx_pair = {tpos_s, tneg_s};
    reg [1:0] data_pair;

    always @*
    begin
        if (desync_on)
            // held back until reading starts, else the head bit would leave twice
            data_pair = (started_reg && fifo_out_valid) ? fifo_out : 2'h0;
        else if (remote_lb)
            data_pair = rx_pair;
        else
            data_pair = tx_pair;
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            line_out_pos <= 1'b0;
            line_out_neg <= 1'b0;
            mark_phase_reg <= 1'b0;
        end
        else if (tx_tick)
        begin
            if (all_ones_active)
            begin
                // data inputs are not looked at here
                line_out_pos <= !mark_phase_reg;
                line_out_neg <= mark_phase_reg;
                mark_phase_reg <= !mark_phase_reg;
            end
            else
            begin
                line_out_pos <= data_pair[1];
                line_out_neg <= data_pair[0];
            end
        end
    end

    // ----------------------------------------
    // digital loopback toward receive side
    // ----------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            loop_out_pos <= 1'b0;
            loop_out_neg <= 1'b0;
        end
        else if (tclk_rise && loopback_mode == `TAOI_LB_DIGITAL)
        begin
            loop_out_pos <= tpos_s;
            loop_out_neg <= tneg_s;
        end
    end

endmodule

// ### taoi_mapper.sv
// far-side model: mapper transmit clock, dual-rail data and receive side
`timescale 1ns/1ps
module taoi_mapper (
    input wire clk,
    input wire resetn,
    input wire gap,
    output reg transmit_clock_in,
    output wire tx_pos_in,
    output wire tx_neg_in,
    output wire rx_clock_in,
    output wire rx_pos_in,
    output wire rx_neg_in
);
    reg [4:0] cnt_reg;
    // ----
    // line clock, eight clk per bit
    // ----
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= 5'h0;
            transmit_clock_in <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 5'h1;
            // gapping drops every fourth pulse, as a de-mapper does
            transmit_clock_in <= cnt_reg[2] & ~(gap & (cnt_reg[4:3] == 2'h3));
        end
    end
    // steady rails keep normal data apart from the all-ones pattern
    assign tx_pos_in = 1'b1;
    assign tx_neg_in = 1'b0;
    assign rx_clock_in = transmit_clock_in;
    assign rx_pos_in = 1'b0;
    assign rx_neg_in = 1'b1;
endmodule

// ### taoi_tx_all_ones_sva.sv
// checker for the transmit all-ones insertion block
`timescale 1ns/1ps
`include "taoi_defs.vh"
module taoi_tx_all_ones_sva (
    input wire clk,
    input wire resetn,
    input wire host_mode,
    input wire all_ones_force,
    input wire all_ones_ctrl_bit,
    input wire [1:0] loopback_mode,
    input wire [1:0] ja_mode,
    input wire ja_in_tx_path,
    input wire transmit_clock_in,
    input wire line_out_pos,
    input wire line_out_neg,
    input wire all_ones_active,
    input wire desync_overflow
);
    reg tclk_prev_reg;
    reg [3:0] since_reg;
    reg [4:0] act_reg;
    wire rise = transmit_clock_in & ~tclk_prev_reg;
    // pattern is only judged once the entry tick has surely passed
    wire live = act_reg >= 5'hc;
    wire lb_none = loopback_mode == `TAOI_LB_NONE;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tclk_prev_reg <= 1'b0;
            since_reg <= 4'h0;
            act_reg <= 5'h0;
        end
        else
        begin
            tclk_prev_reg <= transmit_clock_in;
            since_reg <= rise ? 4'h0 : since_reg + (since_reg != 4'hf);
            act_reg <= !all_ones_active ? 5'h0 : act_reg + (act_reg != 5'h1f);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    AST_PIN: assert property ((!host_mode && all_ones_force && lb_none)[*5] |-> all_ones_active)
        else $error("pin request not honoured");
    AST_HOST: assert property ((host_mode && all_ones_ctrl_bit && lb_none)[*3] |-> all_ones_active)
        else $error("control bit not honoured");
    AST_IDLE: assert property ((host_mode ? !all_ones_ctrl_bit : !all_ones_force)[*5] |-> !all_ones_active)
        else $error("pattern without request");
    AST_BLOCK: assert property ((loopback_mode == `TAOI_LB_ANALOG || loopback_mode == `TAOI_LB_REMOTE)[*2] |-> !all_ones_active)
        else $error("pattern during analog or remote loopback");
    AST_DIG: assert property ((host_mode && all_ones_ctrl_bit && loopback_mode == `TAOI_LB_DIGITAL)[*3] |-> all_ones_active)
        else $error("pattern refused in digital loopback");
    AST_AMI: assert property (live |-> line_out_pos != line_out_neg)
        else $error("gap in the ones stream");
    AST_ALT: assert property (live && line_out_pos |-> ##[1:9] (line_out_neg || !all_ones_active))
        else $error("mark polarity did not alternate");
    AST_TICK: assert property (live && $changed(line_out_pos) |-> since_reg >= 4'h1 && since_reg <= 4'h5)
        else $error("mark not paced by the transmit clock");
    AST_OVF: assert property (desync_overflow |-> ja_mode == `TAOI_JA_DESYNC && ja_in_tx_path)
        else $error("overflow outside de-sync mode");
    cover property (live && loopback_mode == `TAOI_LB_DIGITAL);
    cover property (live && !host_mode);
    cover property (host_mode && all_ones_ctrl_bit && loopback_mode == `TAOI_LB_REMOTE);
    cover property (ja_mode == `TAOI_JA_DESYNC && line_out_pos);
endmodule
bind taoi_tx_all_ones taoi_tx_all_ones_sva u_sva (.clk, .resetn, .host_mode, .all_ones_force,
    .all_ones_ctrl_bit, .loopback_mode, .ja_mode, .ja_in_tx_path, .transmit_clock_in,
    .line_out_pos, .line_out_neg, .all_ones_active, .desync_overflow);

// ### taoi_tx_all_ones_test.sv
// testbench for the transmit all-ones insertion block and its fifo
`timescale 1ns/1ps
`include "taoi_defs.vh"
module taoi_tx_all_ones_test;
    reg clk = 0, resetn = 0, host_mode = 0, all_ones_force = 0, all_ones_ctrl_bit = 0;
    reg ja_in_tx_path = 0, gap = 0;
    reg [1:0] loopback_mode = 0, ja_mode = `TAOI_JA_OFF;
    wire transmit_clock_in, tx_pos_in, tx_neg_in, rx_clock_in, rx_pos_in, rx_neg_in;
    wire line_out_pos, line_out_neg, loop_out_pos, loop_out_neg;
    wire all_ones_active, desync_overflow;
    integer failures = 0, n_compared = 0, i;
    taoi_mapper PEER (.clk, .resetn, .gap, .transmit_clock_in, .tx_pos_in, .tx_neg_in,
        .rx_clock_in, .rx_pos_in, .rx_neg_in);
    taoi_tx_all_ones DUT (.clk, .resetn, .host_mode, .all_ones_force, .all_ones_ctrl_bit,
        .loopback_mode, .ja_mode, .ja_in_tx_path, .transmit_clock_in, .tx_pos_in, .tx_neg_in,
        .rx_clock_in, .rx_pos_in, .rx_neg_in, .line_out_pos, .line_out_neg, .loop_out_pos,
        .loop_out_neg, .all_ones_active, .desync_overflow);
    initial forever #25 clk = ~clk;
    task cmp(input [63:0] nm, input [2:0] s, input [2:0] e);
    begin
        n_compared = n_compared + 1;
        if (s !== e)
        begin
            failures = failures + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, s);
        end
    end
    endtask
    task set(input h, input f, input c, input [1:0] lb, input [1:0] ja);
    begin
        @(posedge clk);
        host_mode <= h;
        all_ones_force <= f;
        all_ones_ctrl_bit <= c;
        loopback_mode <= lb;
        ja_mode <= ja;
    end
    endtask
    // one tick is exactly eight clk, so a sample eight later sees the next mark
    task chk_alt;
        reg p;
    begin
        repeat (20) @(posedge clk);
        #1 p = line_out_pos;
        cmp("pair", line_out_pos ^ line_out_neg, 3'h1);
        repeat (8) @(posedge clk);
        #1 cmp("next", {line_out_pos, line_out_neg}, {~p, p});
    end
    endtask
    task t_pin;
    begin
        set(0, 1, 0, `TAOI_LB_NONE, `TAOI_JA_OFF);
        repeat (5) @(posedge clk);
        #1 cmp("pin_on", all_ones_active, 3'h1);
        chk_alt;
        set(0, 0, 1, `TAOI_LB_NONE, `TAOI_JA_OFF);
        repeat (5) @(posedge clk);
        #1 cmp("pin_off", all_ones_active, 3'h0);
    end
    endtask
    task t_host;
    begin
        set(1, 0, 1, `TAOI_LB_NONE, `TAOI_JA_OFF);
        repeat (2) @(posedge clk);
        #1 cmp("bit_on", all_ones_active, 3'h1);
        chk_alt;
        set(1, 1, 0, `TAOI_LB_NONE, `TAOI_JA_OFF);
        repeat (3) @(posedge clk);
        #1 cmp("bit_off", all_ones_active, 3'h0);
    end
    endtask
    task t_block;
    begin
        for (i = 1; i < 3; i = i + 1)
        begin
            set(1, 1, 1, i[1:0], `TAOI_JA_OFF);
            repeat (20) @(posedge clk);
            #1 cmp("blocked", all_ones_active, 3'h0);
            cmp("lb_data", {line_out_pos, line_out_neg}, (i == 1) ? 3'h2 : 3'h1);
        end
    end
    endtask
    task t_dig;
    begin
        set(1, 0, 1, `TAOI_LB_DIGITAL, `TAOI_JA_OFF);
        repeat (3) @(posedge clk);
        #1 cmp("dig_on", all_ones_active, 3'h1);
        chk_alt;
        cmp("loop", {loop_out_pos, loop_out_neg}, 3'h2);
    end
    endtask
    task t_desync;
    begin
        set(1, 0, 0, `TAOI_LB_NONE, `TAOI_JA_DESYNC);
        ja_in_tx_path <= 1;
        // at most two ticks in twelve clk: nothing may leave before two bits wait
        repeat (12) @(posedge clk);
        #1 cmp("fill", {line_out_pos, line_out_neg}, 3'h0);
        @(posedge clk);
        gap <= 1;
        repeat (80) @(posedge clk);
        #1 cmp("desync", {line_out_pos, line_out_neg}, 3'h2);
        cmp("no_ovf", desync_overflow, 3'h0);
        @(posedge clk);
        gap <= 0;
    end
    endtask
    // buffer seen through the top: leave de-sync with bits parked, return, it must drain
    task t_fifo;
    begin
        set(1, 0, 0, `TAOI_LB_NONE, `TAOI_JA_OFF);
        ja_in_tx_path <= 0;
        repeat (20) @(posedge clk);
        #1 cmp("direct", {line_out_pos, line_out_neg}, 3'h2);
        set(1, 0, 0, `TAOI_LB_NONE, `TAOI_JA_DESYNC);
        ja_in_tx_path <= 1;
        for (i = 0; i < 40; i = i + 1)
        begin
            @(posedge clk);
            #1 cmp("no_loss", desync_overflow, 3'h0);
        end
        cmp("resume", {line_out_pos, line_out_neg}, 3'h2);
    end
    endtask
    task results;
    begin
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1;
        t_pin;
        t_host;
        t_block;
        t_dig;
        t_desync;
        t_fifo;
        results;
    end
endmodule
